// ### src/dcc_pkg.sv
// Package for the DAC calibration cache: register map, fields, reset values, modes
package dcc_pkg;
    // Register offsets (word addresses on the plain register port)
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_LOAD = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_SET_BASE = 8'h10;
    // Set address: base + level*32 + set*4 + field
    localparam int LEVEL_POS = 5;
    localparam int SET_POS = 2;
    localparam logic [1:0] FLD_INPUT = 2'h0;
    localparam logic [1:0] FLD_GAIN = 2'h1;
    localparam logic [1:0] FLD_OFFSET = 2'h2;
    localparam logic [1:0] FLD_CODE = 2'h3;
    // Reset values of the trims and words, then the engine offset bias and the code ceiling
    localparam logic [15:0] GAIN_RST = 16'hFFFF;
    localparam logic [15:0] OFFSET_RST = 16'h8000;
    localparam logic [15:0] INPUT_RST = 16'h0000;
    localparam logic [15:0] CODE_RST = 16'h0000;
    localparam logic [16:0] OFFSET_BIAS = 17'h08000;
    localparam logic [15:0] CODE_MAX = 16'hFFFF;
    // Level count and sets per level
    localparam int NUM_LEVELS = 5;
    localparam int FULL_SETS = 6;
    localparam int CLAMP_SETS = 2;
    // Operating modes: force voltage, four internal current ranges, external range
    typedef enum logic [2:0] {
        DCC_FV,
        DCC_FI_R0,
        DCC_FI_R1,
        DCC_FI_R2,
        DCC_FI_R3,
        DCC_FI_EXT
    } dcc_mode_t;
    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } dcc_req_t;
endpackage

// ### src/dcc_engine.sv
// Calibration engine: code = (gain+1)/2^16 * input + offset - 2^15, saturated
`timescale 1ns/10ps
`default_nettype none
module dcc_engine
(
    input wire logic [15:0] input_word_i,
    input wire logic [15:0] gain_i,
    input wire logic [15:0] offset_i,
    output logic [15:0] code_o
);
    wire [32:0] product;
    wire [16:0] scaled;
    wire signed [18:0] sum;
    // Full-precision product then truncate, so quarter scale keeps 16-bit steps
    assign product = ({16'h0000, gain_i} + 32'h0000_0001) * {17'h00000, input_word_i};
    assign scaled = product[32:16];
    assign sum = $signed({2'b00, scaled}) + $signed({3'b000, offset_i})
        - $signed({2'b00, dcc_pkg::OFFSET_BIAS});
    // Clip instead of wrapping so an overdriven trim stays at a rail
    assign code_o = sum[18] ? 16'h0000 :
        (sum[17:16] != 2'b00) ? dcc_pkg::CODE_MAX : sum[15:0];
endmodule // dcc_engine
`default_nettype wire

// ### src/dcc_cache.sv
// DAC calibration cache: trims, input words and cached codes per level and mode
`timescale 1ns/10ps
`default_nettype none
module dcc_cache
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic load_defer_i,
    output logic [15:0] rdata_o,
    output logic [15:0] dac_code_o [dcc_pkg::NUM_LEVELS],
    output logic [2:0] active_mode_o
);
    localparam int NL = dcc_pkg::NUM_LEVELS;
    localparam int NS = dcc_pkg::FULL_SETS;

    // The map gives the level three address bits and the set three more;
    // bigger tables would alias onto other registers, so refuse them here
    if (dcc_pkg::NUM_LEVELS > 7 || dcc_pkg::FULL_SETS > 8
        || dcc_pkg::CLAMP_SETS > dcc_pkg::FULL_SETS)
    begin : g_map_check
        $error("dcc_cache: set table does not fit the address map");
    end

    // Levels 0 force input, 1-2 comparator high/low, 3-4 clamp high/low
    function automatic int sets_of(input int lvl);
        return (lvl >= 3) ? dcc_pkg::CLAMP_SETS : dcc_pkg::FULL_SETS;
    endfunction

    // Mode to set index; clamps fold all current ranges onto set 1
    function automatic logic [2:0] set_of(input int lvl, input logic [2:0] mode);
        if (lvl >= 3)
        begin
            return (mode == 3'(dcc_pkg::DCC_FV)) ? 3'h0 : 3'h1;
        end
        return mode;
    endfunction

    // Bus request bundled in the package carrier
    dcc_pkg::dcc_req_t req;
    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    // Storage is a full rectangle; clamp sets 2..5 exist but no address reaches them,
    // which keeps the generate loop uniform at the cost of a few idle flops
    logic [15:0] input_q [NL][NS];
    logic [15:0] gain_q [NL][NS];
    logic [15:0] offset_q [NL][NS];
    logic [15:0] code_q [NL][NS];
    logic [15:0] dac_q [NL];
    logic [2:0] mode_q;
    logic defer_q;
    logic pend_q;
    logic [15:0] rdata_q;

    // Field decode of a set access
    wire set_hit = req.addr >= dcc_pkg::REG_SET_BASE;
    wire [7:0] set_off = req.addr - dcc_pkg::REG_SET_BASE;
    wire [2:0] acc_lvl = set_off[7:dcc_pkg::LEVEL_POS];
    wire [2:0] acc_set = set_off[4:dcc_pkg::SET_POS];
    wire [1:0] acc_fld = set_off[1:0];
    wire mode_wr = req.wr && req.addr == dcc_pkg::REG_MODE
        && req.wdata[2:0] <= 3'(dcc_pkg::DCC_FI_EXT);
    wire load_wr = req.wr && req.addr == dcc_pkg::REG_LOAD;
    wire [2:0] next_mode = mode_wr ? req.wdata[2:0] : mode_q;

    // Any input-word write, used to note a change held back by deferral
    wire in_any_wr = req.wr && set_hit && acc_fld == dcc_pkg::FLD_INPUT;
    // A set that exists for its level; others read as zero and ignore writes
    wire set_ok = set_hit && acc_lvl < 3'(NL) && int'(acc_set) < sets_of(int'(acc_lvl));
    // Deferral held either by the pin or by the software bit
    wire deferred = load_defer_i || defer_q;

    // One slice per level and one engine per set; the engines run all the time,
    // trading area for a result that is ready in the cycle of the write
    genvar l, s;
    generate
        for (l = 0; l < NL; l++)
        begin : g_lvl
            // Results of all sets of this level; only the active set's result feeds the DAC directly
            logic [15:0] calc [NS];
            logic act_wr;
            for (s = 0; s < NS; s++)
            begin : g_set
                wire hit = set_hit && acc_lvl == 3'(l) && acc_set == 3'(s)
                    && s < sets_of(l);
                wire in_wr = req.wr && hit && acc_fld == dcc_pkg::FLD_INPUT;
                // The engine sees the word being written, so the result is stored with it
                dcc_engine u_eng
                (
                    .input_word_i(in_wr ? req.wdata : input_q[l][s]),
                    .gain_i(gain_q[l][s]),
                    .offset_i(offset_q[l][s]),
                    .code_o(calc[s])
                );
                // Trim writes only store; the code is refreshed on input writes
                always_ff @(posedge mclk_i)
                begin
                    if (rst_i)
                    begin
                        input_q[l][s] <= dcc_pkg::INPUT_RST;
                        gain_q[l][s] <= dcc_pkg::GAIN_RST;
                        offset_q[l][s] <= dcc_pkg::OFFSET_RST;
                        code_q[l][s] <= dcc_pkg::CODE_RST;
                    end
                    else if (req.wr && hit)
                    begin
                        if (acc_fld == dcc_pkg::FLD_INPUT)
                        begin
                            input_q[l][s] <= req.wdata;
                            code_q[l][s] <= calc[s];
                        end
                        if (acc_fld == dcc_pkg::FLD_GAIN)
                            gain_q[l][s] <= {req.wdata[15:1], 1'b1};
                        if (acc_fld == dcc_pkg::FLD_OFFSET)
                            offset_q[l][s] <= req.wdata;
                    end
                end
            end
            // Write to the set that the active mode uses
            assign act_wr = req.wr && set_hit && acc_lvl == 3'(l)
                && acc_fld == dcc_pkg::FLD_INPUT && acc_set == set_of(l, mode_q);
            // Next DAC word: the fresh result of the active set, or the cached code
            wire reload = !deferred && (mode_wr || pend_q || load_wr);
            wire direct = !deferred && act_wr;
            wire [15:0] fresh = calc[set_of(l, mode_q)];
            wire [15:0] cached = code_q[l][set_of(l, next_mode)];
            // A fresh result wins over a pending reload, since it is newer than the cache
            wire [15:0] sel_code = (act_wr && !mode_wr) ? fresh : cached;
            // DAC register: direct update, mode selection, or released deferral
            always_ff @(posedge mclk_i)
            begin
                if (rst_i)
                    dac_q[l] <= dcc_pkg::CODE_RST;
                else if (reload)
                    dac_q[l] <= sel_code;
                else if (direct)
                    dac_q[l] <= fresh;
            end
            // Straight from the register, so the DAC never sees a decode glitch
            assign dac_code_o[l] = dac_q[l];
        end
    endgenerate

    // Mode, deferral bit and pending-load flag
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mode_q <= 3'(dcc_pkg::DCC_FV);
            defer_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else
        begin
            // Refused mode codes never get here: mode_wr has filtered them
            if (mode_wr)
                mode_q <= req.wdata[2:0];
            if (load_wr)
                defer_q <= req.wdata[0];
            // A change held back by deferral is applied once it lifts
            // Set and clear never meet: one needs deferral, the other its absence
            if (deferred && (mode_wr || in_any_wr))
                pend_q <= 1'b1;
            else if (!deferred)
                pend_q <= 1'b0;
        end
    end

    // Readback, one cycle after the strobe; unmapped reads return zero
    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        if (req.addr == dcc_pkg::REG_MODE)
            rd_mux = {13'h0000, mode_q};
        else if (req.addr == dcc_pkg::REG_LOAD)
            rd_mux = {15'h0000, defer_q};
        else if (req.addr == dcc_pkg::REG_STATUS)
            rd_mux = {14'h0000, load_defer_i, pend_q};
        // Status shows the pin beside the pending flag, so software sees why a load waits
        else if (set_ok)
        begin
            case (acc_fld)
                dcc_pkg::FLD_INPUT: rd_mux = input_q[acc_lvl][acc_set];
                dcc_pkg::FLD_GAIN: rd_mux = gain_q[acc_lvl][acc_set];
                dcc_pkg::FLD_OFFSET: rd_mux = offset_q[acc_lvl][acc_set];
                default: rd_mux = code_q[acc_lvl][acc_set];
            endcase
        end
    end

    // Read data stand one cycle only and fall back to zero
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rdata_q <= 16'h0000;
        else if (req.rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= 16'h0000;
    end
    // Outputs straight from their registers
    assign rdata_o = rdata_q;
    assign active_mode_o = mode_q;
endmodule // dcc_cache
`default_nettype wire

// ### sim/dcc_cache_assertions.sv
// Port checker for the DAC calibration cache
`timescale 1ns/10ps
`default_nettype none
module dcc_cache_chk
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic load_defer_i,
    input wire logic [15:0] rdata_o,
    input wire logic [15:0] dac_code_o [dcc_pkg::NUM_LEVELS],
    input wire logic [2:0] active_mode_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Decodes; codes are flattened so one check covers all levels
    wire logic [79:0] codes = {dac_code_o[0], dac_code_o[1], dac_code_o[2], dac_code_o[3],
        dac_code_o[4]};
    wire logic mwr = wr_i && addr_i == dcc_pkg::REG_MODE;
    wire logic twr = wr_i && addr_i >= dcc_pkg::REG_SET_BASE && addr_i[1:0] != 2'h0;
    wire logic lwr = wr_i && addr_i == dcc_pkg::REG_LOAD;
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("rdata not idle");
    AST_RD_UNMAP: assert property (rd_i && addr_i == 8'h03 |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    AST_RD_MODE: assert property (rd_i && addr_i == 8'h00 |=> rdata_o[2:0] == active_mode_o)
        else $error("mode readback wrong");
    AST_MODE_SET: assert property (mwr && wdata_i[2:0] <= 3'h5 |=>
        active_mode_o == $past(wdata_i[2:0])) else $error("mode not taken");
    AST_MODE_BAD: assert property (mwr && wdata_i[2:0] > 3'h5 |=> $stable(active_mode_o))
        else $error("bad mode taken");
    AST_MODE_HOLD: assert property (!mwr |=> $stable(active_mode_o))
        else $error("mode moved");
    AST_DEFER_HOLD: assert property (load_defer_i |=> $stable(codes))
        else $error("dac moved while deferred");
    AST_TRIM_NOCALC: assert property (twr && !$past(lwr) && !load_defer_i
        && !$past(load_defer_i) |=> $stable(codes)) else $error("trim write moved dac");
    cover property (mwr && wdata_i[2:0] > 3'h5);
    cover property (load_defer_i ##1 !load_defer_i);
    cover property (twr);
    cover property (lwr);
endmodule // dcc_cache_chk
bind dcc_cache dcc_cache_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .load_defer_i(load_defer_i),
    .rdata_o(rdata_o), .dac_code_o(dac_code_o), .active_mode_o(active_mode_o));
`default_nettype wire

// ### sim/dcc_host.sv
// Host model driving the register port
`timescale 1ns/10ps
`default_nettype none
module dcc_host
(
    input wire logic mclk_i,
    input wire logic [15:0] rdata_i,
    output var dcc_pkg::dcc_req_t req_o
);
    initial req_o = '0;
    // One-cycle strobe; release waits an edge so no signal is driven twice at once
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        req_o <= '{1'b1, 1'b0, a, d};
        @(posedge mclk_i);
        req_o <= '0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        req_o <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge mclk_i);
        req_o <= '0;
        #1;
        d = rdata_i;
    endtask
    // Trim from measured errors: gain can only shrink, so only positive error is fixed
    task automatic cal(input logic [7:0] b, input logic [15:0] zerr, gerr);
        wr({b[7:2], dcc_pkg::FLD_OFFSET}, dcc_pkg::OFFSET_RST + zerr);
        wr({b[7:2], dcc_pkg::FLD_GAIN}, dcc_pkg::GAIN_RST - gerr);
    endtask
endmodule // dcc_host
`default_nettype wire

// ### sim/dac_calibration_cache_test.sv
// Self-checking bench for the DAC calibration cache
`timescale 1ns/10ps
`default_nettype none
module dac_calibration_cache_test;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic load_defer_i = 1'b0;
    logic [15:0] rdata_o;
    logic [15:0] dac_code_o [dcc_pkg::NUM_LEVELS];
    logic [2:0] active_mode_o;
    dcc_pkg::dcc_req_t req;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    logic [15:0] r;
    always #5 mclk_i = ~mclk_i;
    dcc_host host (.mclk_i(mclk_i), .rdata_i(rdata_o), .req_o(req));
    dcc_cache dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(req.addr), .wdata_i(req.wdata),
        .wr_i(req.wr), .rd_i(req.rd), .load_defer_i(load_defer_i), .rdata_o(rdata_o),
        .dac_code_o(dac_code_o), .active_mode_o(active_mode_o));
    function automatic logic [7:0] sa(input int l, s, f);
        return 8'(16 + l * 32 + s * 4 + f);
    endfunction
    function automatic logic [15:0] v(input int l, s);
        return 16'(l * 4096 + s * 256 + 17);
    endfunction
    // Saturating reference of the calibrated code; gain bit 0 counts as one
    function automatic logic [15:0] ex(input logic [15:0] x, g, c);
        logic [35:0] t;
        t = ((36'(g | 16'h0001) + 36'h1) * 36'(x) >> 16) + 36'(c) - 36'h8000;
        return t[35] ? 16'h0000 : (t > 36'hFFFF ? 16'hFFFF : t[15:0]);
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge mclk_i);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset;
        host.rd(sa(2, 4, 1), r);
        chk(r, 16'hFFFF);
        host.rd(sa(2, 4, 2), r);
        chk(r, 16'h8000);
        host.rd(8'h00, r);
        chk(r, 16'h0000);
    endtask
    // Preload every set, then step all modes; clamp sets 2..5 must be ignored
    task automatic t_modes;
        for (int l = 0; l < 5; l++)
            for (int s = 0; s < 6; s++)
                host.wr(sa(l, s, 0), v(l, s));
        for (int m = 0; m < 8; m++)
        begin
            host.wr(8'h00, 16'(m));
            tick;
            chk({13'h0, active_mode_o}, 16'(m > 5 ? 5 : m));
            for (int l = 0; l < 5; l++)
                chk(dac_code_o[l], v(l, l > 2 ? int'(m != 0) : (m > 5 ? 5 : m)));
        end
        host.wr(8'h00, 16'h0000);
    endtask
    task automatic t_defer;
        @(posedge mclk_i);
        load_defer_i <= 1'b1;
        host.wr(sa(1, 0, 0), 16'h0ABC);
        tick;
        chk(dac_code_o[1], v(1, 0));
        @(posedge mclk_i);
        load_defer_i <= 1'b0;
        tick;
        chk(dac_code_o[1], 16'h0ABC);
    endtask
    // Software deferral holds the DAC; clearing it loads the cached code
    task automatic t_load;
        host.wr(8'h01, 16'h0001);
        host.wr(sa(0, 0, 0), 16'h0000);
        tick;
        chk(dac_code_o[0], 16'hFFFF);
        host.rd(8'h02, r);
        chk(r, 16'h0001);
        host.rd(8'h01, r);
        chk(r, 16'h0001);
        host.wr(8'h01, 16'h0000);
        tick;
        chk(dac_code_o[0], ex(16'h0000, 16'hFFFF, 16'hFFFF));
    endtask
    task automatic t_calc;
        host.cal(sa(0, 0, 0), 16'h0005, 16'hBFFF);
        tick;
        chk(dac_code_o[0], v(0, 0));
        host.rd(sa(0, 0, 1), r);
        chk(r, 16'h4001);
        host.wr(sa(0, 0, 0), 16'hFFFF);
        tick;
        chk(dac_code_o[0], ex(16'hFFFF, 16'h4000, 16'h8005));
    endtask
    task automatic t_sat;
        host.wr(sa(0, 0, 2), 16'h0000);
        host.wr(sa(0, 0, 0), 16'h0000);
        tick;
        chk(dac_code_o[0], 16'h0000);
        host.wr(sa(0, 0, 1), 16'hFFFF);
        host.wr(sa(0, 0, 2), 16'hFFFF);
        host.wr(sa(0, 0, 0), 16'hFFFF);
        tick;
        chk(dac_code_o[0], 16'hFFFF);
        host.rd(8'h03, r);
        chk(r, 16'h0000);
    endtask
    // Hang guard
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            miscompares++;
            test_done;
        end
    end
    initial
    begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset;
        t_modes;
        t_defer;
        t_calc;
        t_sat;
        t_load;
        test_done;
    end
endmodule // dac_calibration_cache_test
`default_nettype wire
